// file: verilog/ascc_control.sv
// Sample and conversion sequencer with control register and interrupt
`timescale 1ns/1ns
`include "ascc_map.svh"
module ascc_control
  import ascc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [`ASCC_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic sleepMode,
  input wire logic extInterruptPinZero,
  input wire logic timer3Match,
  input wire logic timer1Match,
  input wire logic multiCaptureUnitOne,
  input wire logic multiCaptureUnitTwo,
  input wire logic singleCaptureUnitFour,
  input wire logic logicCellTwo,
  input wire logic [11:0] analogSample,
  output logic sampling,
  output logic converting,
  output logic irq
);
  localparam logic [`ASCC_CNT_W-1:0] CONV10 = `ASCC_CNT_W'(`ASCC_CONV_CYC_10);
  localparam logic [`ASCC_CNT_W-1:0] CONV12 = `ASCC_CNT_W'(`ASCC_CONV_CYC_12);
  // Enable has its own word so a clear write never rewrites the enables
  localparam logic [`ASCC_ADDR_W-1:0] OFF_EN = `ASCC_OFF_IRQ_EN;

  typedef struct packed {
    ascc_state_t state;
    logic enable;
    logic [3:0] sel;
    logic resolution_sel;
    logic autoSample;
    logic done;
    logic [`ASCC_CNT_W-1:0] count;
    logic [`ASCC_IRQ_W-1:0] irqStat;
    logic [`ASCC_IRQ_W-1:0] irqEn;
    logic [31:0] rdata;
  } ascc_ctl_state_t;

  ascc_ctl_state_t s_q;
  ascc_ctl_state_t s_d;
  logic trigger;
  logic manualFall;
  logic convEnd;
  logic startSample;
  logic ctrlWrite;
  logic [11:0] result;
  logic [31:0] ctrlView;

  ////////////////////////////////////////////////////////////
  assign ctrlWrite = regWrite && regAddr == `ASCC_OFF_CTRL;
  // Software clearing the command while sampling in manual mode
  assign manualFall = ctrlWrite && s_q.enable && regWdata[`ASCC_BIT_ON]
    && s_q.state == ST_SAMPLE && !regWdata[`ASCC_BIT_SAMPLE];
  assign convEnd = s_q.state == ST_CONVERT && s_q.count == '0;

  ascc_trigger_mux u_mux (
    .clock(clock),
    .rst_n(rst_n),
    .triggerSourceSel(s_q.sel),
    .sleepMode(sleepMode),
    .manualFall(manualFall),
    .extInterruptPinZero(extInterruptPinZero),
    .timer3Match(timer3Match),
    .timer1Match(timer1Match),
    .multiCaptureUnitOne(multiCaptureUnitOne),
    .multiCaptureUnitTwo(multiCaptureUnitTwo),
    .singleCaptureUnitFour(singleCaptureUnitFour),
    .logicCellTwo(logicCellTwo),
    .trigger(trigger)
  );

  ascc_result_reg u_result (
    .clock(clock),
    .rst_n(rst_n),
    .load(convEnd),
    .sampleIn(analogSample),
    .resolution_sel(s_q.resolution_sel),
    .result(result)
  );

  assign ctrlView = {16'h0, s_q.enable, 7'h0, s_q.sel, s_q.resolution_sel, s_q.autoSample,
    s_q.state == ST_SAMPLE, s_q.done};

  ////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    startSample = 1'b0;
    if (ctrlWrite) begin
      s_d.enable = regWdata[`ASCC_BIT_ON];
      s_d.sel = regWdata[`ASCC_SEL_HI:`ASCC_SEL_LO];
      s_d.resolution_sel = regWdata[`ASCC_BIT_RESOLUTION_SEL];
      s_d.autoSample = regWdata[`ASCC_BIT_AUTO];
      // Done is clear-only from software; no effect on sequencing
      if (!regWdata[`ASCC_BIT_DONE]) begin
        s_d.done = 1'b0;
      end
    end
    case (s_q.state)
      ST_IDLE: begin
        if (ctrlWrite && s_q.enable && regWdata[`ASCC_BIT_ON] && !s_q.autoSample
            && regWdata[`ASCC_BIT_SAMPLE]) begin
          s_d.state = ST_SAMPLE;
          startSample = 1'b1;
        end else if (s_q.enable && s_q.autoSample) begin
          s_d.state = ST_SAMPLE;
          startSample = 1'b1;
        end
      end
      ST_SAMPLE: begin
        if (trigger) begin
          s_d.state = ST_CONVERT;
          s_d.count = s_q.resolution_sel ? CONV12 : CONV10;
        end
      end
      ST_CONVERT: begin
        if (convEnd) begin
          s_d.done = 1'b1;
          // Auto mode goes straight back to sampling
          if (s_q.autoSample && s_q.enable) begin
            s_d.state = ST_SAMPLE;
            startSample = 1'b1;
          end else begin
            s_d.state = ST_IDLE;
          end
        end else begin
          s_d.count = s_q.count - 1'b1;
        end
      end
      default: s_d.state = ST_IDLE;
    endcase
    if (startSample && s_q.autoSample) begin
      s_d.done = 1'b0;
    end
    // Turning off drops sampling; a running conversion still finishes
    if (!s_d.enable && s_d.state == ST_SAMPLE) begin
      s_d.state = ST_IDLE;
    end
    if (regWrite && regAddr == `ASCC_OFF_IRQ_CLR) begin
      s_d.irqStat = s_d.irqStat & ~regWdata[`ASCC_IRQ_W-1:0];
    end
    if (regWrite && regAddr == OFF_EN) begin
      s_d.irqEn = regWdata[`ASCC_IRQ_W-1:0];
    end
    // Set wins over a same-cycle clear
    if (convEnd) begin
      s_d.irqStat[`ASCC_IRQ_DONE] = 1'b1;
    end
    if (startSample) begin
      s_d.irqStat[`ASCC_IRQ_START] = 1'b1;
    end
    s_d.rdata = 32'h0;
    if (regRead) begin
      case (regAddr)
        `ASCC_OFF_CTRL: s_d.rdata = ctrlView;
        `ASCC_OFF_RESULT: s_d.rdata = {20'h0, result};
        `ASCC_OFF_IRQ_STAT: s_d.rdata = {30'h0, s_q.irqStat};
        OFF_EN: s_d.rdata = {30'h0, s_q.irqEn};
        default: s_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{state: ST_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdata = s_q.rdata;
  assign sampling = s_q.state == ST_SAMPLE;
  assign converting = s_q.state == ST_CONVERT;
  assign irq = |(s_q.irqStat & s_q.irqEn);
endmodule

// file: verilog/ascc_map.svh
// Register map, field positions and timing constants of the converter sequencer
//
// Functional notes
// - Selector bits 7:4 pick trigger; 1111/1011/1001 mapped
// - Code 1000: multi capture unit one triggers
// - Code 0010: timer three period match triggers
// - Code 0111: timer one match, not in sleep
// - Code 0001: external interrupt pin edge triggers
// - Code 0000: sample command falling starts conversion
// - Bit 3 selects twelve or ten bit
// - Auto sample restarts sampling after each conversion
// - Without auto sample, wait for command set
// - Bit 1 reads one while sampling
// - Manual mode: writing one starts sampling
// - Code 0000: writing zero launches conversion
// - Bit 0 set once conversion finished; an auto restart clears it in the same cycle
// - Clearing done never aborts running work
// - Auto modes clear done at next sample
// - Disabled: sample command held low, writes ignored
`ifndef ASCC_MAP_SVH
`define ASCC_MAP_SVH
`define ASCC_ADDR_W 5
`define ASCC_OFF_CTRL 5'h00
`define ASCC_OFF_RESULT 5'h04
`define ASCC_OFF_IRQ_STAT 5'h08
`define ASCC_OFF_IRQ_CLR 5'h0c
`define ASCC_OFF_IRQ_EN 5'h10
`define ASCC_BIT_ON 15
`define ASCC_BIT_RESOLUTION_SEL 3
`define ASCC_BIT_AUTO 2
`define ASCC_BIT_SAMPLE 1
`define ASCC_BIT_DONE 0
`define ASCC_SEL_HI 7
`define ASCC_SEL_LO 4
`define ASCC_CTRL_RESET 32'h00000000
`define ASCC_CLK_MHZ 125
`define ASCC_CONV_NS_10 1000
`define ASCC_CONV_NS_12 1200
`define ASCC_CONV_CYC_10 ((`ASCC_CONV_NS_10 * `ASCC_CLK_MHZ + 999) / 1000)
`define ASCC_CONV_CYC_12 ((`ASCC_CONV_NS_12 * `ASCC_CLK_MHZ + 999) / 1000)
`define ASCC_CNT_W 8
`define ASCC_IRQ_DONE 0
`define ASCC_IRQ_START 1
`define ASCC_IRQ_W 2
`endif

// file: verilog/ascc_pkg.sv
// Types shared by the converter sequencer files
package ascc_pkg;
  typedef enum logic [3:0] {
    SRC_MANUAL = 4'h0,
    SRC_EXT_EXT_INTERRUPT_PIN_ZERO = 4'h1,
    SRC_TIMER3 = 4'h2,
    SRC_TIMER1 = 4'h7,
    SRC_MCCP_ONE = 4'h8,
    SRC_MCCP_TWO = 4'h9,
    SRC_SCCP_FOUR = 4'hb,
    SRC_LOGIC_TWO = 4'hf
  } ascc_src_t;
  typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT} ascc_state_t;
endpackage

// file: verilog/ascc_trigger_mux.sv
// Trigger source selection for the end of sampling
`timescale 1ns/1ns
`include "ascc_map.svh"
module ascc_trigger_mux
  import ascc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] triggerSourceSel,
  input wire logic sleepMode,
  input wire logic manualFall,
  input wire logic extInterruptPinZero,
  input wire logic timer3Match,
  input wire logic timer1Match,
  input wire logic multiCaptureUnitOne,
  input wire logic multiCaptureUnitTwo,
  input wire logic singleCaptureUnitFour,
  input wire logic logicCellTwo,
  output logic trigger
);
  typedef struct packed {
    logic extPrev;
  } ascc_tm_state_t;
  ascc_tm_state_t s_q;
  ascc_tm_state_t s_d;
  logic extEdge;

  always_comb begin
    s_d = s_q;
    s_d.extPrev = extInterruptPinZero;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Rising transition counts as the active edge
  assign extEdge = extInterruptPinZero & ~s_q.extPrev;

  always_comb begin
    case (triggerSourceSel)
      SRC_MANUAL: trigger = manualFall;
      SRC_EXT_EXT_INTERRUPT_PIN_ZERO: trigger = extEdge;
      SRC_TIMER3: trigger = timer3Match;
      SRC_TIMER1: trigger = timer1Match & ~sleepMode;
      SRC_MCCP_ONE: trigger = multiCaptureUnitOne;
      SRC_MCCP_TWO: trigger = multiCaptureUnitTwo;
      SRC_SCCP_FOUR: trigger = singleCaptureUnitFour;
      SRC_LOGIC_TWO: trigger = logicCellTwo;
      default: trigger = 1'b0;
    endcase
  end
endmodule

// file: verilog/ascc_result_reg.sv
// Result holding register of the converter
`timescale 1ns/1ns
module ascc_result_reg (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [11:0] sampleIn,
  input wire logic resolution_sel,
  output logic [11:0] result
);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result <= 12'h000;
    end else if (load) begin
      // Ten bit mode keeps the top ten bits, right aligned
      result <= resolution_sel ? sampleIn : {2'h0, sampleIn[11:2]};
    end
  end
endmodule

// file: dv/ascc_event_src.sv
// Model of the peripheral event sources feeding the trigger lines
`timescale 1ns/1ns
module ascc_event_src (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] code,
  input wire logic fire,
  output logic [6:0] ev
);
  // One-cycle pulses; the pin line drops again so each fire is a fresh rise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ev <= 7'h0;
    end else begin
      ev <= 7'h0;
      if (fire) begin
        case (code)
          4'h1: ev[0] <= 1'h1;
          4'h2: ev[1] <= 1'h1;
          4'h7: ev[2] <= 1'h1;
          4'h8: ev[3] <= 1'h1;
          4'h9: ev[4] <= 1'h1;
          4'hb: ev[5] <= 1'h1;
          4'hf: ev[6] <= 1'h1;
          default: ev <= 7'h0;
        endcase
      end
    end
  end
endmodule

// file: dv/ascc_control_assertions.sv
// Port checker for the converter sequencer
`timescale 1ns/1ns
`include "ascc_map.svh"
module ascc_control_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [`ASCC_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic sleepMode,
  input wire logic extInterruptPinZero,
  input wire logic timer3Match,
  input wire logic sampling,
  input wire logic converting
);
  logic ctrlWr;
  logic [3:0] selQ;
  logic enQ;
  assign ctrlWr = regWrite && regAddr == `ASCC_OFF_CTRL;
  // Shadow of selector and enable, so checks know the active setup
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      selQ <= 4'h0;
      enQ <= 1'h0;
    end else if (ctrlWr) begin
      selQ <= regWdata[7:4];
      enQ <= regWdata[15];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_sample_start: assert property (ctrlWr && enQ && regWdata[15] && regWdata[1] && !converting |=> sampling)
    else $error("sampling did not start");
  a_manual_conv: assert property (sampling && ctrlWr && selQ == 4'h0 && regWdata[15] && !regWdata[1]
    |=> converting)
    else $error("manual conversion not launched");
  a_disable_hold: assert property (ctrlWr && !regWdata[15] |=> !sampling)
    else $error("sampling while disabled");
  a_state_excl: assert property (!(sampling && converting))
    else $error("sampling and converting together");
  a_conv_span: assert property ($rose(converting) |-> converting[*8])
    else $error("conversion ended too early");
  a_timer3_trig: assert property (sampling && selQ == 4'h2 && timer3Match |-> ##[1:3] converting)
    else $error("timer three event ignored");
  a_pin_trig: assert property (sampling && selQ == 4'h1 && $rose(extInterruptPinZero) |-> ##[1:3] converting)
    else $error("pin edge ignored");
  a_sleep_block: assert property ((sampling && selQ == 4'h7 && sleepMode)[*3] |-> !converting)
    else $error("conversion started in sleep");
endmodule
bind ascc_control ascc_control_assertions u_chk (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .sleepMode(sleepMode), .extInterruptPinZero(extInterruptPinZero),
  .timer3Match(timer3Match), .sampling(sampling), .converting(converting));

// file: dv/ascc_control_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
`include "ascc_map.svh"
module ascc_control_tb;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic [`ASCC_ADDR_W-1:0] regAddr = '0;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'h0;
  logic regRead = 1'h0;
  logic sleepMode = 1'h0;
  logic fire = 1'h0;
  logic [3:0] code = 4'h0;
  logic [6:0] ev;
  logic [31:0] regRdata;
  logic sampling;
  logic converting;
  logic irq;
  int err_count = 0;
  int total_checks = 0;
  ascc_control dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .sleepMode(sleepMode), .extInterruptPinZero(ev[0]),
    .timer3Match(ev[1]), .timer1Match(ev[2]), .multiCaptureUnitOne(ev[3]), .multiCaptureUnitTwo(ev[4]),
    .singleCaptureUnitFour(ev[5]), .logicCellTwo(ev[6]), .analogSample(12'habc), .sampling(sampling),
    .converting(converting), .irq(irq));
  ascc_event_src src (.clock(clock), .rst_n(rst_n), .code(code), .fire(fire), .ev(ev));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [`ASCC_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clock);
    regWrite <= wr;
    regRead <= !wr;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'h0;
    regRead <= 1'h0;
    #1;
    if (!wr) check(regRdata, d);
  endtask
  task automatic trig(input logic [3:0] c);
    @(posedge clock);
    code <= c;
    fire <= 1'h1;
    @(posedge clock);
    fire <= 1'h0;
  endtask
  // Bounded: a stuck sequencer must still reach the verdict
  task automatic waitc(input logic lvl);
    int n = 0;
    while (converting !== lvl && n < 400) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 400) begin
      err_count++;
      print_verdict();
    end
  endtask
  ////////////////////////////////////////
  task automatic t_manual();
    bus(1, `ASCC_OFF_IRQ_CLR, 32'h3);
    bus(1, `ASCC_OFF_IRQ_EN, 32'h1);
    bus(0, `ASCC_OFF_IRQ_EN, 32'h1);
    // Enable first: the sample bit needs the converter already on
    bus(1, `ASCC_OFF_CTRL, 32'h8000);
    check(sampling, 1'h0);
    bus(1, `ASCC_OFF_CTRL, 32'h8002);
    #8 check(sampling, 1'h1);
    bus(1, `ASCC_OFF_CTRL, 32'h8000);
    #8 check(converting, 1'h1);
    check(irq, 1'h0);
    waitc(1'h0);
    #8 check(irq, 1'h1);
    bus(0, `ASCC_OFF_CTRL, 32'h8001);
    bus(0, `ASCC_OFF_RESULT, 32'h2af);
    bus(0, `ASCC_OFF_IRQ_STAT, 32'h3);
    bus(1, `ASCC_OFF_IRQ_CLR, 32'h3);
    #8 check(irq, 1'h0);
    bus(0, 5'h02, 32'h0);
    $display("manual test done");
  endtask
  task automatic t_trig();
    logic [3:0] codes [7] = '{4'h1, 4'h2, 4'h7, 4'h8, 4'h9, 4'hb, 4'hf};
    foreach (codes[i]) begin
      bus(1, `ASCC_OFF_CTRL, {24'h80, codes[i], 4'ha});
      trig(codes[i]);
      waitc(1'h1);
      check(converting, 1'h1);
      waitc(1'h0);
      bus(0, `ASCC_OFF_CTRL, {24'h80, codes[i], 4'h9});
      bus(0, `ASCC_OFF_RESULT, 32'habc);
    end
    $display("trigger test done");
  endtask
  task automatic t_block();
    bus(1, `ASCC_OFF_CTRL, 32'h8032);
    trig(4'h2);
    repeat (4) @(posedge clock);
    sleepMode <= 1'h1;
    #1 check(converting, 1'h0);
    bus(1, `ASCC_OFF_CTRL, 32'h8072);
    trig(4'h7);
    repeat (4) @(posedge clock);
    sleepMode <= 1'h0;
    #1 check(converting, 1'h0);
    bus(1, `ASCC_OFF_CTRL, 32'h0072);
    #8 check(sampling, 1'h0);
    bus(0, `ASCC_OFF_CTRL, 32'h0070);
    $display("block test done");
  endtask
  task automatic t_auto();
    bus(1, `ASCC_OFF_CTRL, 32'h8024);
    #16 check(sampling, 1'h1);
    trig(4'h2);
    waitc(1'h1);
    bus(1, `ASCC_OFF_CTRL, 32'h8024);
    check(converting, 1'h1);
    waitc(1'h0);
    check(sampling, 1'h1);
    bus(0, `ASCC_OFF_CTRL, 32'h8026);
    bus(1, `ASCC_OFF_CTRL, 32'h0);
    $display("auto test done");
  endtask
  initial begin
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'h1;
    bus(0, `ASCC_OFF_CTRL, 32'h0);
    t_manual();
    t_trig();
    t_block();
    t_auto();
    print_verdict();
  end
endmodule
